//--- verilog/swd_regs.svh
// Constants of the serial wiper command decoder
// Functional notes
// - A frame is 16 bits: two zero pad bits, four command bits, ten data bits.
// - Frame bits arrive most significant first, starting at bit 15.
// - Select stays low over the word; decoding happens when select returns high.
// - Clocks count in 16-bit units; only whole multiples of 16 act correctly.
// - Command 0 leaves wiper, flags and shutdown alone; the frame itself is echoed out next frame.
// - Command 1 loads the wiper setting, only when write unlock is set.
// - Command 2 shifts the wiper setting out next frame, low ten bits.
// - Command 3 stores the wiper into the next free memory slot if enabled.
// - Command 4 reloads the wiper setting from stored memory.
// - Command 5 picks a memory slot or status word by data bits 4..0.
// - Command 6 writes data bits 2..0 into control flags 2..0.
// - Command 7 shifts the control flags out next frame, in the low four bits.
// - Command 8 enters shutdown on data bit 0 set, leaves on clear.
// - In the 256-step variant the two lowest wiper bits are don't-care.
// - Twenty one-time memory slots, each written at most once.
// - Each store is verified and its outcome recorded in the program-ok flag.
// - A store takes about 8 ms; incoming frames are ignored meanwhile.
// - Ready shows that a store and its verification are complete.
// - Write unlock is 0 after power-up, blocking wiper writes except reloads.
// - Program enable resets to 0 and blocks stores until set.
// - Calibration select defaults 0 for precision mode; 1 selects normal mode.
// - Program-ok defaults 0 and reads 1 only after a verified store.
// - Serial input is sampled on falling serial clock while select is low.
// - A frame cut short before sixteen clocks is discarded.
// - A rising hardware reset pin while no store runs reloads the wiper from the last stored slot.
// - Reset or reload with empty memory gives midscale and default control flags.
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH

`define SWD_CMD_NOP        4'h0
`define SWD_CMD_WRITE      4'h1
`define SWD_CMD_READ_WIPER 4'h2
`define SWD_CMD_STORE      4'h3
`define SWD_CMD_REFRESH    4'h4
`define SWD_CMD_READ_MEM   4'h5
`define SWD_CMD_WRITE_CTRL 4'h6
`define SWD_CMD_READ_CTRL  4'h7
`define SWD_CMD_SHUTDOWN   4'h8

`define SWD_MEM_SLOTS      5'h14
`define SWD_STATUS_LO_ADDR 5'h14
`define SWD_STATUS_HI_ADDR 5'h15
`define SWD_THERMO_SPLIT   5'h0A
`define SWD_MID_SCALE      10'h200
`define SWD_LOW_BITS_MASK  10'h3FC
`define SWD_CTRL_RESET     4'h0
`define SWD_CTRL_PE_BIT    0
`define SWD_CTRL_UNLOCK_BIT 1
`define SWD_CTRL_CAL_BIT   2
`define SWD_CTRL_OK_BIT    3

`define SWD_CLK_MHZ        40
`define SWD_STORE_TIME_US  8000
`define SWD_STORE_CYCLES   (`SWD_STORE_TIME_US * `SWD_CLK_MHZ)

`endif

//--- verilog/swd_pkg.sv
// Types shared by the serial wiper command decoder
package swd_pkg;
   typedef struct packed {
      logic [1:0] pad;
      logic [3:0] cmd;
      logic [9:0] data;
   } swd_frame_type;

   typedef enum logic [1:0] {SWD_IDLE, SWD_STORE, SWD_VERIFY} swd_state_type;
endpackage

//--- verilog/swd_link.sv
// Serial link shifter running on the serial clock
`timescale 1ns/1ps
module swd_link
   import swd_pkg::*;
(
   input wire logic resetn,
   input wire logic serial_clk,
   input wire logic frame_sel_n,
   input wire logic serial_in,
   input wire logic [15:0] tx_word,
   output swd_frame_type rx_frame,
   output logic rx_whole,
   output logic serial_out,
   output logic serial_out_oe
);
   logic first_reg;
   logic [15:0] shift_reg;
   logic [3:0] cnt_reg;
   logic seen16_reg;
   logic [3:0] opos_reg;

   // Frame start marker, set while select is high; reset too, so the first frame never sees X
   always_ff @(negedge serial_clk or posedge frame_sel_n or negedge resetn) begin
      if (!resetn) begin
         first_reg <= 1'b1;
      end else if (frame_sel_n) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   // Shift and bit count survive select rising so the system side can read them
   always_ff @(negedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         shift_reg <= 16'h0000;
         cnt_reg <= 4'h0;
         seen16_reg <= 1'b0;
      end else begin
         shift_reg <= {shift_reg[14:0], serial_in};
         if (first_reg) begin
            cnt_reg <= 4'h1;
            seen16_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'hF) begin
               seen16_reg <= 1'b1;
            end
         end
      end
   end

   assign rx_frame = swd_frame_type'(shift_reg);
   assign rx_whole = seen16_reg && (cnt_reg == 4'h0);

   // Output bits change on the rising edge, ahead of the sampling edge
   always_ff @(posedge serial_clk or posedge frame_sel_n) begin
      if (frame_sel_n) begin
         opos_reg <= 4'h0;
         serial_out <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         opos_reg <= opos_reg + 4'h1;
         serial_out <= tx_word[4'hF - opos_reg];
         serial_out_oe <= ~tx_word[4'hF - opos_reg];
      end
   end
endmodule

//--- verilog/swd_top.sv
// Serial wiper command decoder: frame decode, wiper, control flags, one-time memory
`timescale 1ns/1ps
`include "swd_regs.svh"
module swd_top
   import swd_pkg::*;
#(
   parameter int STORE_CYCLES = `SWD_STORE_CYCLES,
   parameter bit RES_256 = 1'b0
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic serial_clk,
   input wire logic frame_sel_n,
   input wire logic serial_in,
   input wire logic hw_reset_n,
   output logic [9:0] wiper_setting,
   output logic [3:0] control_flags,
   output logic shutdown,
   output logic ready,
   output logic serial_out,
   output logic serial_out_oe
);
   localparam int TW = $clog2(STORE_CYCLES + 1);

   swd_frame_type rx_frame;
   logic rx_whole;
   logic [15:0] tx_word_reg;
   logic [9:0] wiper_setting_reg;
   logic [3:0] control_flags_reg;
   logic shutdown_reg;
   logic ready_reg;
   logic [9:0] mem_reg [`SWD_MEM_SLOTS];
   logic [4:0] used_reg;
   swd_state_type state_reg;
   logic [TW-1:0] timer_reg;
   logic fsel_meta_reg, fsel_sync_reg, fsel_prev_reg;
   logic hwr_meta_reg, hwr_sync_reg, hwr_prev_reg;
   logic frame_done, hwr_rise, take, refresh, store_go;
   logic [9:0] last_value;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] wmask(input logic [9:0] v);
      return RES_256 ? (v & `SWD_LOW_BITS_MASK) : v;
   endfunction

   function automatic logic [9:0] thermo(input logic [4:0] n);
      logic [9:0] t;
      t = 10'h000;
      for (int i = 0; i < 10; i++) begin
         if (5'(i) < n) begin
            t[i] = 1'b1;
         end
      end
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   swd_link u_link (
      .resetn(resetn),
      .serial_clk(serial_clk),
      .frame_sel_n(frame_sel_n),
      .serial_in(serial_in),
      .tx_word(tx_word_reg),
      .rx_frame(rx_frame),
      .rx_whole(rx_whole),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the link word is quiet once select is seen high here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fsel_meta_reg <= 1'b1;
         fsel_sync_reg <= 1'b1;
         fsel_prev_reg <= 1'b1;
      end else begin
         fsel_meta_reg <= frame_sel_n;
         fsel_sync_reg <= fsel_meta_reg;
         fsel_prev_reg <= fsel_sync_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hwr_meta_reg <= 1'b1;
         hwr_sync_reg <= 1'b1;
         hwr_prev_reg <= 1'b1;
      end else begin
         hwr_meta_reg <= hw_reset_n;
         hwr_sync_reg <= hwr_meta_reg;
         hwr_prev_reg <= hwr_sync_reg;
      end
   end

   assign frame_done = fsel_sync_reg && !fsel_prev_reg;
   assign hwr_rise = hwr_sync_reg && !hwr_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Decode strobes; a busy store or partial frame takes nothing
   assign take = frame_done && rx_whole && (state_reg == SWD_IDLE);
   assign refresh = (take && rx_frame.cmd == `SWD_CMD_REFRESH)
      || (hwr_rise && state_reg == SWD_IDLE);
   assign store_go = take && rx_frame.cmd == `SWD_CMD_STORE
      && control_flags_reg[`SWD_CTRL_PE_BIT] && used_reg < `SWD_MEM_SLOTS;
   assign last_value = (used_reg == 5'h00) ? `SWD_MID_SCALE
      : mem_reg[used_reg - 5'h01];

   ////////////////////////////////////////////////////////////////////////////
   // Wiper setting
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wiper_setting_reg <= `SWD_MID_SCALE;
      end else if (refresh) begin
         wiper_setting_reg <= last_value;
      end else if (take && rx_frame.cmd == `SWD_CMD_WRITE
                   && control_flags_reg[`SWD_CTRL_UNLOCK_BIT]) begin
         wiper_setting_reg <= wmask(rx_frame.data);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control flags; program-ok is written by the store verify and cleared by a reload
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         control_flags_reg <= `SWD_CTRL_RESET;
      end else if (state_reg == SWD_VERIFY) begin
         control_flags_reg[`SWD_CTRL_OK_BIT] <=
            (mem_reg[used_reg] == wiper_setting_reg);
      end else if (refresh) begin
         control_flags_reg <= `SWD_CTRL_RESET;
      end else if (take && rx_frame.cmd == `SWD_CMD_WRITE_CTRL) begin
         control_flags_reg[2:0] <= rx_frame.data[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shutdown_reg <= 1'b0;
      end else if (take && rx_frame.cmd == `SWD_CMD_SHUTDOWN) begin
         shutdown_reg <= rx_frame.data[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-time memory: a slot is written once, the count only grows
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < `SWD_MEM_SLOTS; i++) begin
            mem_reg[i] <= 10'h000;
         end
      end else if (store_go) begin
         mem_reg[used_reg] <= wiper_setting_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         used_reg <= 5'h00;
      end else if (state_reg == SWD_VERIFY) begin
         used_reg <= used_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Store sequencer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= SWD_IDLE;
         timer_reg <= '0;
      end else begin
         case (state_reg)
            SWD_IDLE: begin
               if (store_go) begin
                  state_reg <= SWD_STORE;
                  timer_reg <= TW'(STORE_CYCLES - 1);
               end
            end
            SWD_STORE: begin
               if (timer_reg == '0) begin
                  state_reg <= SWD_VERIFY;
               end else begin
                  timer_reg <= timer_reg - 1'b1;
               end
            end
            SWD_VERIFY: begin
               state_reg <= SWD_IDLE;
            end
            default: begin
               state_reg <= SWD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ready_reg <= 1'b1;
      end else if (store_go) begin
         ready_reg <= 1'b0;
      end else if (state_reg == SWD_VERIFY) begin
         ready_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word for the next frame; changes only while select is high
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_word_reg <= 16'h0000;
      end else if (take) begin
         case (rx_frame.cmd)
            `SWD_CMD_READ_WIPER: begin
               tx_word_reg <= {6'h00, wmask(wiper_setting_reg)};
            end
            `SWD_CMD_READ_MEM: begin
               if (rx_frame.data[4:0] < `SWD_MEM_SLOTS) begin
                  tx_word_reg <= {6'h00, mem_reg[rx_frame.data[4:0]]};
               end else if (rx_frame.data[4:0] == `SWD_STATUS_LO_ADDR) begin
                  tx_word_reg <= {6'h00, thermo(used_reg)};
               end else if (rx_frame.data[4:0] == `SWD_STATUS_HI_ADDR) begin
                  tx_word_reg <= {6'h00, thermo((used_reg > `SWD_THERMO_SPLIT)
                     ? used_reg - `SWD_THERMO_SPLIT : 5'h00)};
               end else begin
                  tx_word_reg <= 16'h0000;
               end
            end
            `SWD_CMD_READ_CTRL: begin
               tx_word_reg <= {12'h000, control_flags_reg};
            end
            default: begin
               tx_word_reg <= rx_frame;
            end
         endcase
      end
   end

   assign wiper_setting = wiper_setting_reg;
   assign control_flags = control_flags_reg;
   assign shutdown = shutdown_reg;
   assign ready = ready_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_store_end;
      state_reg == SWD_VERIFY ##1 state_reg == SWD_IDLE && ready_reg;
   endsequence

   sequence s_store_open;
      state_reg == SWD_STORE && !ready_reg;
   endsequence

   a_nop_no_change:
   assert property (take && rx_frame.cmd == `SWD_CMD_NOP && !hwr_rise |=>
      $stable(wiper_setting_reg) && $stable(control_flags_reg) && $stable(shutdown_reg))
      else $error("nop changed state");

   a_write_locked:
   assert property (take && rx_frame.cmd == `SWD_CMD_WRITE
      && !control_flags_reg[`SWD_CTRL_UNLOCK_BIT] && !hwr_rise |=> $stable(wiper_setting_reg))
      else $error("locked wiper was written");

   a_write_loads:
   assert property (take && rx_frame.cmd == `SWD_CMD_WRITE
      && control_flags_reg[`SWD_CTRL_UNLOCK_BIT] && !hwr_rise |=>
      wiper_setting_reg == wmask($past(rx_frame.data)))
      else $error("wiper write lost");

   a_store_starts:
   assert property (store_go |=> s_store_open)
      else $error("store did not start");

   a_store_finish:
   assert property (state_reg == SWD_STORE && timer_reg == '0 |=> s_store_end)
      else $error("store did not complete with ready");

   a_busy_ignores:
   assert property (state_reg != SWD_IDLE && frame_done |=>
      $stable(control_flags_reg[2:0]) && $stable(shutdown_reg) && $stable(tx_word_reg))
      else $error("frame taken during store");

   a_store_needs_pe:
   assert property (take && rx_frame.cmd == `SWD_CMD_STORE
      && !control_flags_reg[`SWD_CTRL_PE_BIT] |=> state_reg == SWD_IDLE && $stable(used_reg))
      else $error("store without program enable");

   a_ok_after_verify:
   assert property ($rose(control_flags_reg[`SWD_CTRL_OK_BIT]) |->
      $past(state_reg) == SWD_VERIFY)
      else $error("program ok rose outside verify");

   a_refresh_empty:
   assert property (refresh && used_reg == 5'h00 |=>
      wiper_setting_reg == `SWD_MID_SCALE && control_flags_reg == `SWD_CTRL_RESET)
      else $error("empty refresh not midscale");

   a_partial_drop:
   assert property (frame_done && !rx_whole && !hwr_rise |=>
      $stable(wiper_setting_reg) && $stable(tx_word_reg) && $stable(shutdown_reg))
      else $error("partial frame executed");

   a_ctrl_readback:
   assert property (take && rx_frame.cmd == `SWD_CMD_READ_CTRL |=>
      tx_word_reg == {12'h000, control_flags_reg})
      else $error("control readback wrong");

   a_shutdown_set:
   assert property (take && rx_frame.cmd == `SWD_CMD_SHUTDOWN && !hwr_rise |=>
      shutdown_reg == $past(rx_frame.data[0]) && $stable(wiper_setting_reg))
      else $error("shutdown command wrong");
endmodule

//--- dv/swd_ctrl_model.sv
// Behavioural serial controller that frames words onto the wiper decoder link
`timescale 1ns/1ps
module swd_ctrl_model (
   output logic serial_clk,
   output logic frame_sel_n,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   logic sdo_wire;

   // Open-drain line with a pull-up: low only while the device pulls it
   assign sdo_wire = serial_out_oe ? 1'b0 : 1'b1;

   initial begin
      serial_clk = 1'b0;
      frame_sel_n = 1'b1;
      serial_in = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sends the low nbits of word, top bit first; rx keeps the last 16 bits seen
   task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      // Odd offset keeps the link clock out of step with the system clock
      #7;
      frame_sel_n = 1'b0;
      for (i = nbits - 1; i >= 0; i--) begin
         #16 serial_clk = 1'b1;
         serial_in = word[i];
         #32 serial_clk = 1'b0;
         rx = {rx[14:0], sdo_wire};
         #16;
      end
      #16 frame_sel_n = 1'b1;
      // Released data line is not left at its last value
      serial_in = ~serial_in;
      // Gap lets the decode land before the next frame or a register check
      #250;
   endtask
endmodule

//--- dv/test_serial_wiper_command_decoder.sv
// Self-checking bench for the serial wiper command decoder
`timescale 1ns/1ps
`include "swd_regs.svh"
module test_serial_wiper_command_decoder;
   import swd_pkg::*;
   localparam int STORE_N = 200;
   logic clk_sys;
   logic resetn;
   logic hw_reset_n;
   logic serial_clk;
   logic frame_sel_n;
   logic serial_in;
   logic [9:0] wiper_setting;
   logic [3:0] control_flags;
   logic shutdown;
   logic ready;
   logic serial_out;
   logic serial_out_oe;
   logic [15:0] rx;
   int mismatches;
   int n_compared;
   int low_cnt;
   int i;

   swd_top #(.STORE_CYCLES(STORE_N), .RES_256(1'b0)) dut (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .serial_clk(serial_clk),
      .frame_sel_n(frame_sel_n),
      .serial_in(serial_in),
      .hw_reset_n(hw_reset_n),
      .wiper_setting(wiper_setting),
      .control_flags(control_flags),
      .shutdown(shutdown),
      .ready(ready),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe)
   );

   swd_ctrl_model master (
      .serial_clk(serial_clk),
      .frame_sel_n(frame_sel_n),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe)
   );

   always #12.5 clk_sys = ~clk_sys;

   // Counts system cycles with ready low, to measure the store span
   always @(posedge clk_sys) begin
      if (ready !== 1'b1) begin
         low_cnt <= low_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   function automatic logic [15:0] fw(input logic [3:0] c, input logic [9:0] d);
      return {2'b00, c, d};
   endfunction

   task automatic raw(input logic [31:0] word, input int nbits);
      master.xfer(word, nbits, rx);
      @(negedge clk_sys);
   endtask

   task automatic frame(input logic [3:0] c, input logic [9:0] d);
      raw({16'h0000, fw(c, d)}, 16);
   endtask

   task automatic check_wiper(input logic [9:0] exp);
      check({6'h00, wiper_setting}, {6'h00, exp});
   endtask

   task automatic check_ctrl(input logic [3:0] exp);
      check({12'h000, control_flags}, {12'h000, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      hw_reset_n = 1'b1;
      mismatches = 0;
      n_compared = 0;
      low_cnt = 0;
      repeat (8) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
      check_wiper(10'h200);
      check_ctrl(4'h0);
      check({14'h0000, shutdown, ready}, 16'h0001);
      // Write while locked, then unlock; upper control data is ignored
      frame(`SWD_CMD_WRITE, 10'h155);
      check_wiper(10'h200);
      frame(`SWD_CMD_WRITE_CTRL, 10'h3FE);
      check(rx, fw(`SWD_CMD_WRITE, 10'h155));
      check_ctrl(4'h6);
      frame(`SWD_CMD_WRITE, 10'h155);
      check_wiper(10'h155);
      frame(`SWD_CMD_READ_WIPER, 10'h3FF);
      frame(`SWD_CMD_NOP, 10'h3FF);
      check(rx, 16'h0155);
      check_wiper(10'h155);
      frame(`SWD_CMD_READ_CTRL, 10'h000);
      frame(`SWD_CMD_NOP, 10'h000);
      check(rx, 16'h0006);
      // Short, odd and double-length frames
      raw({16'h0000, fw(`SWD_CMD_WRITE, 10'h0AA) >> 4}, 12);
      check_wiper(10'h155);
      raw({16'h0000, fw(`SWD_CMD_WRITE, 10'h0AA)}, 17);
      check_wiper(10'h155);
      raw({fw(`SWD_CMD_NOP, 10'h000), fw(`SWD_CMD_WRITE, 10'h2AA)}, 32);
      check_wiper(10'h2AA);
      frame(`SWD_CMD_SHUTDOWN, 10'h001);
      check({5'h00, shutdown, wiper_setting}, 16'h06AA);
      frame(`SWD_CMD_SHUTDOWN, 10'h3FE);
      check({5'h00, shutdown, wiper_setting}, 16'h02AA);
      // Store refused without program enable
      frame(`SWD_CMD_STORE, 10'h000);
      check({15'h0000, ready}, 16'h0001);
      frame(`SWD_CMD_READ_MEM, 10'h014);
      frame(`SWD_CMD_NOP, 10'h000);
      check(rx, 16'h0000);
      frame(`SWD_CMD_WRITE_CTRL, 10'h003);
      check_ctrl(4'h3);
      low_cnt = 0;
      frame(`SWD_CMD_STORE, 10'h000);
      check({15'h0000, ready}, 16'h0000);
      // Frame during the store must be dropped
      frame(`SWD_CMD_WRITE, 10'h001);
      for (i = 0; i < 400 && ready !== 1'b1; i++) begin
         @(negedge clk_sys);
      end
      check(16'(low_cnt), 16'(STORE_N + 1));
      check_wiper(10'h2AA);
      check_ctrl(4'hB);
      frame(`SWD_CMD_READ_MEM, 10'h3E0);
      frame(`SWD_CMD_READ_MEM, 10'h014);
      check(rx, 16'h02AA);
      frame(`SWD_CMD_READ_MEM, 10'h015);
      check(rx, 16'h0001);
      frame(`SWD_CMD_NOP, 10'h000);
      check(rx, 16'h0000);
      // Software and pin reloads restore the stored setting
      frame(`SWD_CMD_WRITE, 10'h0F0);
      check_wiper(10'h0F0);
      frame(`SWD_CMD_REFRESH, 10'h000);
      check_wiper(10'h2AA);
      check_ctrl(4'h0);
      frame(`SWD_CMD_WRITE_CTRL, 10'h002);
      frame(`SWD_CMD_WRITE, 10'h0F0);
      check_wiper(10'h0F0);
      hw_reset_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      hw_reset_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      check_wiper(10'h2AA);
      check_ctrl(4'h0);
      // Second reset empties memory, so a reload gives midscale
      resetn = 1'b0;
      repeat (3) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
      frame(`SWD_CMD_WRITE_CTRL, 10'h002);
      frame(`SWD_CMD_WRITE, 10'h0F0);
      frame(`SWD_CMD_REFRESH, 10'h000);
      check_wiper(10'h200);
      give_verdict();
   end
endmodule
